// ==== verilog/march_regs.svh ====
// Register offsets, field positions and reset values of the march test sequencer
`ifndef MARCH_REGS_SVH
`define MARCH_REGS_SVH

`define MARCH_OFF_CTRL 8'h00
`define MARCH_OFF_BG 8'h04
`define MARCH_OFF_STATUS 8'h08
`define MARCH_OFF_FAIL_ADDR 8'h0C

`define MARCH_CTRL_START_BIT 0
`define MARCH_CTRL_ALGO_LSB 4
`define MARCH_CTRL_ALGO_MSB 7

`define MARCH_STAT_BUSY_BIT 0
`define MARCH_STAT_DONE_BIT 1
`define MARCH_STAT_FAIL_BIT 2
`define MARCH_STAT_TMODE_BIT 3

`define MARCH_ALGO_RESET 4'h0
`define MARCH_BG_RESET 32'h0000_0000

`endif

// ==== verilog/march_pkg.sv ====
// Types shared by the march test sequencer
`default_nettype none
package march_pkg;

  typedef enum logic [3:0] {
    ALG_DEFAULT = 4'h0,
    ALG_CW1 = 4'h1,
    ALG_X = 4'h2,
    ALG_CMINUS = 4'h3,
    ALG_CGRAY = 4'h4,
    ALG_C = 4'h5,
    ALG_CPLUS = 4'h6,
    ALG_Y = 4'h7,
    ALG_MOVI = 4'h8,
    ALG_EXT_CMINUS = 4'h9,
    ALG_LR = 4'hA,
    ALG_B = 4'hB,
    ALG_A = 4'hC,
    ALG_17N = 4'hD
  } algo_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_RUN = 5'h04,
    ST_DRAIN = 5'h08,
    ST_DONE = 5'h10
  } state_e;

  // One memory operation: read or write, true or inverted background
  typedef struct packed {
    logic rd;
    logic inv;
  } mop_s;

  // One march element; first op sits in the highest used slot
  typedef struct packed {
    logic last;
    logic down;
    logic [2:0] cnt;
    logic [11:0] ops;
  } elem_s;

endpackage

`default_nettype wire

// ==== verilog/march_addr_gen.sv ====
// Address sweep generator: up or down, binary or single-bit-change order
`timescale 1ns/1ns
`default_nettype none

module march_addr_gen #(
  parameter int AW = 10
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_down,
  input wire logic i_gray,
  input wire logic i_step,
  output logic [AW-1:0] o_addr,
  output logic o_last
);

  localparam logic [AW-1:0] ADDR_MAX = '1;

  logic [AW-1:0] cnt_q;
  logic down_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
      down_q <= 1'b0;
    end else if (i_load) begin
      cnt_q <= i_down ? ADDR_MAX : '0;
      down_q <= i_down;
    end else if (i_step) begin
      cnt_q <= down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
    end
  end

  // Gray of a unit-step count flips exactly one bit per step
  assign o_addr = i_gray ? (cnt_q ^ (cnt_q >> 1)) : cnt_q;
  assign o_last = down_q ? (cnt_q == '0) : (cnt_q == ADDR_MAX);

endmodule

`default_nettype wire

// ==== verilog/march_seq.sv ====
// March algorithm SRAM self-test sequencer with register port
//
// Function
// - CW part one: six elements
// - X: four elements
// - C-minus: six elements
// - Gray C: C-minus ops, one-bit address steps
// - C: seven elements
// - C-plus: six elements with read-backs
// - Y: four elements
// - MOVI: five elements, first descending
// - Extended C-minus: six elements
// - LR: six ascending elements
// - B: five elements
// - A: five elements
// - 17N: eight elements starting with b
// - Ascending binary sweeps zero to highest address; Gray C ends at the Gray code of the highest count
// - Descending binary sweeps highest address to zero; Gray C starts at the Gray code of the highest count
// - Operand a background, b its inverse
// - No algorithm chosen selects C-plus
`timescale 1ns/1ns
`default_nettype none
`include "march_regs.svh"

module march_seq #(
  parameter int AW = 10,
  parameter int DW = 32,
  parameter int SW_W = 2,
  parameter logic [SW_W-1:0] TEST_SW_ASSERT = '1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [SW_W-1:0] i_test_sw,
  output logic [AW-1:0] o_mem_addr,
  output logic [DW-1:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  input wire logic [DW-1:0] i_mem_rdata,
  output logic o_busy,
  output logic o_done,
  output logic o_fail
);
  import march_pkg::*;

  localparam logic UP = 1'b0;
  localparam logic DN = 1'b1;
  localparam logic MORE = 1'b0;
  localparam logic LAST = 1'b1;
  localparam logic [1:0] WA = 2'b00;
  localparam logic [1:0] WB = 2'b01;
  localparam logic [1:0] RA = 2'b10;
  localparam logic [1:0] RB = 2'b11;

  function automatic elem_s mk(logic last, logic down, logic [2:0] cnt, logic [11:0] ops);
    return {last, down, cnt, ops};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Element tables

  function automatic elem_s elem_at(algo_e a, logic [2:0] i);
    elem_s r;
    r = mk(LAST, UP, 3'd1, 12'(RA));
    case ({a, i})
      {ALG_CW1, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_CW1, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_CW1, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, RA}));
      {ALG_CW1, 3'd3}: r = mk(MORE, DN, 3'd3, 12'({RA, WB, RB}));
      {ALG_CW1, 3'd4}: r = mk(MORE, DN, 3'd2, 12'({RB, WA}));
      {ALG_CW1, 3'd5}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_X, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_X, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_X, 3'd2}: r = mk(MORE, DN, 3'd2, 12'({RB, WA}));
      {ALG_X, 3'd3}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_CMINUS, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_CMINUS, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_CMINUS, 3'd2}: r = mk(MORE, UP, 3'd2, 12'({RB, WA}));
      {ALG_CMINUS, 3'd3}: r = mk(MORE, DN, 3'd2, 12'({RA, WB}));
      {ALG_CMINUS, 3'd4}: r = mk(MORE, DN, 3'd2, 12'({RB, WA}));
      {ALG_CMINUS, 3'd5}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_C, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_C, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_C, 3'd2}: r = mk(MORE, UP, 3'd2, 12'({RB, WA}));
      {ALG_C, 3'd3}: r = mk(MORE, UP, 3'd1, 12'(RA));
      {ALG_C, 3'd4}: r = mk(MORE, DN, 3'd2, 12'({RA, WB}));
      {ALG_C, 3'd5}: r = mk(MORE, DN, 3'd2, 12'({RB, WA}));
      {ALG_C, 3'd6}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_CPLUS, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_CPLUS, 3'd1}: r = mk(MORE, UP, 3'd3, 12'({RA, WB, RB}));
      {ALG_CPLUS, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, RA}));
      {ALG_CPLUS, 3'd3}: r = mk(MORE, DN, 3'd3, 12'({RA, WB, RB}));
      {ALG_CPLUS, 3'd4}: r = mk(MORE, DN, 3'd3, 12'({RB, WA, RA}));
      {ALG_CPLUS, 3'd5}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_Y, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_Y, 3'd1}: r = mk(MORE, UP, 3'd3, 12'({RA, WB, RB}));
      {ALG_Y, 3'd2}: r = mk(MORE, DN, 3'd3, 12'({RB, WA, RA}));
      {ALG_Y, 3'd3}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_MOVI, 3'd0}: r = mk(MORE, DN, 3'd1, 12'(WA));
      {ALG_MOVI, 3'd1}: r = mk(MORE, UP, 3'd3, 12'({RA, WB, RB}));
      {ALG_MOVI, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, RA}));
      {ALG_MOVI, 3'd3}: r = mk(MORE, DN, 3'd3, 12'({RA, WB, RB}));
      {ALG_MOVI, 3'd4}: r = mk(LAST, DN, 3'd3, 12'({RB, WA, RA}));
      {ALG_EXT_CMINUS, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_EXT_CMINUS, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_EXT_CMINUS, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, RA}));
      {ALG_EXT_CMINUS, 3'd3}: r = mk(MORE, DN, 3'd2, 12'({RA, WB}));
      {ALG_EXT_CMINUS, 3'd4}: r = mk(MORE, DN, 3'd2, 12'({RB, WA}));
      {ALG_EXT_CMINUS, 3'd5}: r = mk(LAST, DN, 3'd1, 12'(RA));
      {ALG_LR, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_LR, 3'd1}: r = mk(MORE, UP, 3'd2, 12'({RA, WB}));
      {ALG_LR, 3'd2}: r = mk(MORE, UP, 3'd4, 12'({RB, WA, RA, WB}));
      {ALG_LR, 3'd3}: r = mk(MORE, UP, 3'd2, 12'({RB, WA}));
      {ALG_LR, 3'd4}: r = mk(MORE, UP, 3'd4, 12'({RA, WB, RB, WA}));
      {ALG_LR, 3'd5}: r = mk(LAST, UP, 3'd1, 12'(RA));
      {ALG_B, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_B, 3'd1}: r = mk(MORE, UP, 3'd6, {RA, WB, RB, WA, RA, WB});
      {ALG_B, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, WB}));
      {ALG_B, 3'd3}: r = mk(MORE, DN, 3'd4, 12'({RB, WA, WB, WA}));
      {ALG_B, 3'd4}: r = mk(LAST, DN, 3'd3, 12'({RA, WB, WA}));
      {ALG_A, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WA));
      {ALG_A, 3'd1}: r = mk(MORE, UP, 3'd4, 12'({RA, WB, WA, WB}));
      {ALG_A, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, WB}));
      {ALG_A, 3'd3}: r = mk(MORE, DN, 3'd4, 12'({RB, WA, WB, WA}));
      {ALG_A, 3'd4}: r = mk(LAST, DN, 3'd3, 12'({RA, WB, WA}));
      {ALG_17N, 3'd0}: r = mk(MORE, UP, 3'd1, 12'(WB));
      {ALG_17N, 3'd1}: r = mk(MORE, UP, 3'd3, 12'({RB, WA, RA}));
      {ALG_17N, 3'd2}: r = mk(MORE, UP, 3'd3, 12'({RA, WB, RB}));
      {ALG_17N, 3'd3}: r = mk(MORE, UP, 3'd2, 12'({RB, WA}));
      {ALG_17N, 3'd4}: r = mk(MORE, DN, 3'd3, 12'({RA, WB, RB}));
      {ALG_17N, 3'd5}: r = mk(MORE, UP, 3'd1, 12'(RB));
      {ALG_17N, 3'd6}: r = mk(MORE, DN, 3'd3, 12'({RB, WA, RA}));
      {ALG_17N, 3'd7}: r = mk(LAST, UP, 3'd1, 12'(RA));
      default: r = mk(LAST, UP, 3'd1, 12'(RA));
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  state_e state_q, state_d;
  logic [3:0] algo_q;
  logic [DW-1:0] bg_q;
  algo_e run_algo_q;
  logic gray_q;
  logic [2:0] elem_q;
  logic [2:0] op_q;
  logic [AW-1:0] mem_addr_q;
  logic [DW-1:0] mem_wdata_q;
  logic mem_we_q;
  logic mem_re_q;
  logic chk_q;
  logic [DW-1:0] exp_q;
  logic [AW-1:0] chk_addr_q;
  logic fail_q;
  logic [AW-1:0] fail_addr_q;
  logic done_q;
  logic busy_q;
  logic [31:0] rdata_q;
  logic [SW_W-1:0] sw_s1_q, sw_s2_q, sw_s3_q;
  logic tmode_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic wr_ctrl = i_wr && (i_addr == `MARCH_OFF_CTRL);
  wire logic wr_bg = i_wr && (i_addr == `MARCH_OFF_BG);
  wire logic idle = (state_q == ST_IDLE) || (state_q == ST_DONE);
  // Start is honoured only once the test switch sits at its asserted value
  wire logic start = wr_ctrl && i_wdata[`MARCH_CTRL_START_BIT] && idle && tmode_q;

  wire logic [3:0] wr_algo = i_wdata[`MARCH_CTRL_ALGO_MSB:`MARCH_CTRL_ALGO_LSB];
  wire logic algo_known = (wr_algo != 4'(ALG_DEFAULT)) && (wr_algo <= 4'(ALG_17N));
  wire algo_e pick_algo = algo_known ? algo_e'(wr_algo) : ALG_CPLUS;
  wire algo_e tbl_algo = (run_algo_q == ALG_CGRAY) ? ALG_CMINUS : run_algo_q;

  wire elem_s el = elem_at(tbl_algo, elem_q);
  wire logic [2:0] op_slot = el.cnt - 3'd1 - op_q;
  wire mop_s cur_op = el.ops[{op_slot, 1'b0} +: 2];
  wire logic op_last = (op_q == el.cnt - 3'd1);

  wire logic run = (state_q == ST_RUN);
  wire logic [AW-1:0] ag_addr;
  wire logic ag_last;
  wire logic elem_end = run && op_last && ag_last;
  wire logic mismatch = chk_q && (i_mem_rdata != exp_q);

  march_addr_gen #(
    .AW(AW)
  ) u_addr_gen (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_load(state_q == ST_LOAD),
    .i_down(el.down),
    .i_gray(gray_q),
    .i_step(run && op_last && !ag_last),
    .o_addr(ag_addr),
    .o_last(ag_last)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_DONE: begin
        if (start) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: state_d = ST_RUN;
      ST_RUN: begin
        if (elem_end) begin
          state_d = el.last ? ST_DRAIN : ST_LOAD;
        end
      end
      // Last read still in flight must be checked before done
      ST_DRAIN: begin
        if (!mem_re_q && !chk_q) begin
          state_d = ST_DONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      algo_q <= `MARCH_ALGO_RESET;
      bg_q <= DW'(`MARCH_BG_RESET);
    end else if (idle) begin
      if (wr_ctrl) begin
        algo_q <= wr_algo;
      end
      if (wr_bg) begin
        bg_q <= DW'(i_wdata);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
      sw_s3_q <= '0;
      tmode_q <= 1'b0;
    end else begin
      sw_s1_q <= i_test_sw;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q) begin
        tmode_q <= (sw_s3_q == TEST_SW_ASSERT);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      run_algo_q <= ALG_CPLUS;
      gray_q <= 1'b0;
      elem_q <= 3'd0;
      op_q <= 3'd0;
    end else begin
      state_q <= state_d;
      if (start) begin
        run_algo_q <= pick_algo;
        gray_q <= (pick_algo == ALG_CGRAY);
        elem_q <= 3'd0;
      end else if (elem_end && !el.last) begin
        elem_q <= elem_q + 3'd1;
      end
      if (state_q == ST_LOAD || (run && op_last)) begin
        op_q <= 3'd0;
      end else if (run) begin
        op_q <= op_q + 3'd1;
      end
    end
  end

  // A read carries its expected word in the write-data lane
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
    end else begin
      mem_addr_q <= run ? ag_addr : mem_addr_q;
      mem_wdata_q <= run ? (cur_op.inv ? ~bg_q : bg_q) : mem_wdata_q;
      mem_we_q <= run && !cur_op.rd;
      mem_re_q <= run && cur_op.rd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      chk_q <= 1'b0;
      exp_q <= '0;
      chk_addr_q <= '0;
    end else begin
      chk_q <= mem_re_q;
      exp_q <= mem_wdata_q;
      chk_addr_q <= mem_addr_q;
    end
  end

  // Set outranks the clear at start, though start only comes with no read pending
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fail_q <= 1'b0;
      fail_addr_q <= '0;
    end else if (mismatch) begin
      fail_q <= 1'b1;
      fail_addr_q <= fail_q ? fail_addr_q : chk_addr_q;
    end else if (start) begin
      fail_q <= 1'b0;
      fail_addr_q <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= (state_d == ST_DONE);
      busy_q <= (state_d != ST_IDLE) && (state_d != ST_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  wire logic [31:0] stat_word = 32'({tmode_q, fail_q, done_q, busy_q});
  wire logic [31:0] rd_mux =
    (i_addr == `MARCH_OFF_CTRL) ? 32'({algo_q, 4'h0}) :
    (i_addr == `MARCH_OFF_BG) ? 32'(bg_q) :
    (i_addr == `MARCH_OFF_STATUS) ? stat_word :
    (i_addr == `MARCH_OFF_FAIL_ADDR) ? 32'(fail_addr_q) : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;
  assign o_mem_addr = mem_addr_q;
  assign o_mem_wdata = mem_wdata_q;
  assign o_mem_we = mem_we_q;
  assign o_mem_re = mem_re_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_fail = fail_q;

endmodule

`default_nettype wire

// ==== testbench/march_seq_sva.sv ====
// Port assertions for the march test sequencer
`timescale 1ns/1ns
`default_nettype none
`include "march_regs.svh"
module march_seq_sva #(
  parameter int AW = 10,
  parameter int DW = 32,
  parameter int SW_W = 2,
  parameter logic [SW_W-1:0] TEST_SW_ASSERT = '1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic [SW_W-1:0] i_test_sw,
  input wire logic [DW-1:0] o_mem_wdata,
  input wire logic o_mem_we,
  input wire logic o_mem_re,
  input wire logic [DW-1:0] i_mem_rdata,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_fail
);
  wire logic start_wr;
  assign start_wr = i_wr && (i_addr == `MARCH_OFF_CTRL) && i_wdata[0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_ONE_OP: assert property (!(o_mem_we && o_mem_re))
    else $error("write and read in one cycle");
  AST_DONE_NOT_BUSY: assert property (o_done |-> !o_busy)
    else $error("done while busy");
  AST_DONE_HOLDS: assert property (o_done && !start_wr |=> o_done)
    else $error("done dropped without start");
  AST_DONE_RISE: assert property ($rose(o_done) |-> $fell(o_busy) && !o_mem_re)
    else $error("done rose without busy falling");
  AST_IDLE_QUIET: assert property (!o_busy |-> !(o_mem_we || o_mem_re))
    else $error("memory op while idle");
  AST_FAIL_STICKY: assert property (o_fail && !start_wr |=> o_fail)
    else $error("fail flag cleared");
  AST_FAIL_CAUSE: assert property ($rose(o_fail) |-> $past(o_mem_re, 2))
    else $error("fail rose without a read");
  AST_FAIL_MISMATCH: assert property ((o_busy && o_mem_re) ##1
    (i_mem_rdata != $past(o_mem_wdata)) |=> o_fail)
    else $error("mismatch not flagged");
  AST_START_LAUNCH: assert property ((i_test_sw == TEST_SW_ASSERT)[*5] ##0
    (start_wr && !o_busy) |-> ##[1:2] o_busy ##[1:4] (o_mem_we || o_mem_re))
    else $error("start did not launch ops");
endmodule
bind march_seq march_seq_sva #(.AW(AW), .DW(DW), .SW_W(SW_W), .TEST_SW_ASSERT(TEST_SW_ASSERT))
  u_march_seq_sva (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_test_sw(i_test_sw), .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we),
  .o_mem_re(o_mem_re), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
  .o_fail(o_fail));
`default_nettype wire

// ==== testbench/sram_partner.sv ====
// Behavioural single-port SRAM with an optional read fault at one address
`timescale 1ns/1ns
`default_nettype none
module sram_partner #(
  parameter int AW = 3,
  parameter int DW = 32
) (
  input wire logic i_clk,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic i_flip_en,
  input wire logic [AW-1:0] i_flip_addr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [2**AW];
  wire logic flip;
  assign flip = i_flip_en && (i_addr == i_flip_addr);
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    // Toggle outside read cycles so stale data can never pass a compare
    if (i_re) begin
      o_rdata <= mem_q[i_addr] ^ {{(DW-1){1'b0}}, flip};
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/march_seq_test.sv ====
// Self-checking testbench for the march test sequencer
`timescale 1ns/1ns
`default_nettype none
`include "march_regs.svh"
module march_seq_test;
  import march_pkg::*;
  localparam int AW = 3;
  localparam int N = 2**AW;
  localparam logic [31:0] BG = 32'h5A5A_3C3C;
  logic i_clk, i_reset, i_wr, i_rd, mem_we, mem_re, o_busy, o_done, o_fail, flip_en;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, mem_wdata, mem_rdata, rv, first_data;
  logic [1:0] i_test_sw;
  logic [AW-1:0] mem_addr, flip_addr, first_addr, prev_addr;
  int err_count, num_checks, n_rd, n_wr, n_multi;
  // Reads and writes per address, indexed by ALGO code
  int exp_rd [16] = '{9, 7, 3, 5, 5, 6, 9, 5, 8, 6, 7, 6, 4, 11, 9, 9};
  int exp_wr [16] = '{5, 5, 3, 5, 5, 5, 5, 3, 5, 5, 7, 11, 11, 6, 5, 5};

  march_seq #(.AW(AW)) u_march_seq (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_test_sw(i_test_sw),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_we(mem_we), .o_mem_re(mem_re),
    .i_mem_rdata(mem_rdata), .o_busy(o_busy), .o_done(o_done), .o_fail(o_fail));
  sram_partner #(.AW(AW), .DW(32)) u_sram_partner (.i_clk(i_clk), .i_addr(mem_addr),
    .i_wdata(mem_wdata), .i_we(mem_we), .i_re(mem_re), .i_flip_en(flip_en),
    .i_flip_addr(flip_addr), .o_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (mem_we || mem_re) begin
      if (n_rd + n_wr == 0) begin
        first_addr <= mem_addr;
        first_data <= mem_wdata;
      end else if ($countones(mem_addr ^ prev_addr) > 1) begin
        n_multi <= n_multi + 1;
      end
      prev_addr <= mem_addr;
      n_rd <= n_rd + int'(mem_re);
      n_wr <= n_wr + int'(mem_we);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Poke writes the background mid-run; a busy sequencer must ignore it
  task automatic run(input logic [3:0] code, input logic bad, input logic poke);
    n_rd = 0;
    n_wr = 0;
    n_multi = 0;
    wr(`MARCH_OFF_CTRL, {24'h0, code, 4'h1});
    if (poke) wr(`MARCH_OFF_BG, 32'h0000_0000);
    @(posedge i_clk);
    #1;
    for (int k = 0; k < 400 && o_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk("done", 1'b1, o_done);
    chk("reads", exp_rd[code] * N, n_rd);
    chk("writes", exp_wr[code] * N, n_wr);
    chk("first addr", (code == ALG_MOVI) ? N - 1 : 0, first_addr);
    chk("last addr", (code == ALG_LR || code == ALG_17N) ? N - 1 : 0, prev_addr);
    chk("first data", (code == ALG_17N) ? ~BG : BG, first_data);
    if (code == ALG_CGRAY) chk("gray steps", 0, n_multi);
    chk("fail", bad, o_fail);
    rd(`MARCH_OFF_STATUS, rv);
    chk("status", {28'h0, 1'b1, bad, 2'b10}, rv);
    $display("test algo %0d done", code);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_test_sw = 2'b00;
    flip_en = 1'b0;
    flip_addr = '0;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`MARCH_OFF_CTRL, rv);
    chk("ctrl reset", 32'h0000_0000, rv);
    rd(`MARCH_OFF_BG, rv);
    chk("bg reset", 32'h0000_0000, rv);
    rd(8'h10, rv);
    chk("unmapped", 32'h0000_0000, rv);
    wr(`MARCH_OFF_CTRL, 32'h0000_0061);
    repeat (4) @(posedge i_clk);
    #1 chk("busy refused", 1'b0, o_busy);
    rd(`MARCH_OFF_STATUS, rv);
    chk("status refused", 32'h0000_0000, rv);
    @(posedge i_clk);
    #1 chk("rdata idle", 32'h0000_0000, o_rdata);
    $display("test refusal done");
    repeat (6) @(posedge i_clk);
    i_test_sw <= 2'b11;
    repeat (5) @(posedge i_clk);
    wr(`MARCH_OFF_BG, BG);
    for (int c = 0; c < 16; c++) run(c[3:0], 1'b0, 1'b0);
    flip_en <= 1'b1;
    flip_addr <= 3'd5;
    run(ALG_CPLUS, 1'b1, 1'b1);
    rd(`MARCH_OFF_FAIL_ADDR, rv);
    chk("fail addr", 32'h0000_0005, rv);
    rd(`MARCH_OFF_BG, rv);
    chk("bg kept", BG, rv);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
